// [swk_pkg.sv]
// Package: sleep states, wake sources and timing counts for the wake logic
package swk_pkg;
   // Sleep state encodings on the state input
   localparam logic [2:0] SLP_S0 = 3'h0;
   localparam logic [2:0] SLP_S1 = 3'h1;
   localparam logic [2:0] SLP_S3 = 3'h3;
   localparam logic [2:0] SLP_S4 = 3'h4;
   localparam logic [2:0] SLP_S5 = 3'h5;
   // Wake source bit positions
   localparam int SRC_LAN  = 0;
   localparam int SRC_RING = 1;
   localparam int SRC_USB  = 2;
   localparam int SRC_KBMS = 3;
   localparam int SRC_PME  = 4;
   localparam int NSRC     = 5;
   // Front panel lamp codes
   localparam logic [1:0] LAMP_OFF   = 2'h0;
   localparam logic [1:0] LAMP_GREEN = 2'h1;
   localparam logic [1:0] LAMP_AMBER = 2'h2;
   // Power-good wait, in ns, and derived cycles at 200 MHz
   localparam int CLK_NS      = 5;
   localparam int PWR_WAIT_NS = 1000;
   localparam int PWR_WAIT_CY = (PWR_WAIT_NS + CLK_NS - 1) / CLK_NS;
endpackage

// [swk_sync_if.sv]
// Interface: synchronised wake source levels between sync and core
`timescale 1ns/10ps
`default_nettype none
interface swk_sync_if #(parameter int N = 5);
   logic [N-1:0] lvl;
   modport src (output lvl);
   modport dst (input lvl);
endinterface
`default_nettype wire

// [swk_sync.sv]
// Two-stage synchroniser for the wake source inputs
`timescale 1ns/10ps
`default_nettype none
module swk_sync #(
   parameter int N = 5
) (
   // Clock and reset
   input  wire logic   mclk,
   input  wire logic   nrst,
   // Raw inputs and synchronised output
   input  wire logic [N-1:0] raw,
   swk_sync_if.src           sy
);
   logic [N-1:0] meta;
   logic [N-1:0] stab;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         meta <= '0;
         stab <= '0;
      end else begin
         meta <= raw;
         stab <= meta;
      end
   end

   assign sy.lvl = stab;
endmodule
`default_nettype wire

// [swk_core.sv]
// Wake-event qualification and main power sequencing
`timescale 1ns/10ps
`default_nettype none
module swk_core #(
   parameter int PWR_WAIT = swk_pkg::PWR_WAIT_CY
) (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       nrst,
   // System sleep state and entry request
   input  wire logic [2:0] sleep_state,
   input  wire logic       sleep_req,
   // Wake sources, active high except pme_n, which is active low
   input  wire logic       lan_wake,
   input  wire logic       ring_ext,
   input  wire logic       ring_int,
   input  wire logic       usb_act,
   input  wire logic       kbms_act,
   input  wire logic       pme_n,
   // Firmware options and board strap
   input  wire logic       pme_wake_en,
   input  wire logic       lan_s5_en,
   input  wire logic       pme_s5_en,
   input  wire logic       lamp_dual,
   // Power supply, indicator and wake status outputs
   input  wire logic       pwr_good,
   output logic            main_pwr_on,
   output logic [1:0]      lamp,
   output logic            resume_ctx,
   output logic            wake_pulse,
   output logic [4:0]      wake_cause
);
   localparam int NS = swk_pkg::NSRC;

   typedef enum logic [3:0] {
      ST_RUN   = 4'b0001,
      ST_SLEEP = 4'b0010,
      ST_PWRUP = 4'b0100,
      ST_WAKE  = 4'b1000
   } swk_state_e;

   swk_state_e  st;
   swk_state_e  next_st;
   logic [2:0]  held_state;
   logic [NS-1:0] latch;
   logic [15:0] wait_cnt;
   swk_sync_if #(.N(NS)) syi ();

   // Either modem path raises the same ring source
   wire       ring_any = ring_ext | ring_int;
   wire [NS-1:0] raw_src = {~pme_n, kbms_act, usb_act, ring_any, lan_wake};

   swk_sync #(.N(NS)) u_sync (
      .mclk (mclk),
      .nrst (nrst),
      .raw  (raw_src),
      .sy   (syi.src)
   );

   function automatic logic is_light(input logic [2:0] s);
      return (s == swk_pkg::SLP_S1) || (s == swk_pkg::SLP_S3);
   endfunction

   function automatic logic is_deep(input logic [2:0] s);
      return (s == swk_pkg::SLP_S4) || (s == swk_pkg::SLP_S5);
   endfunction

   wire light = is_light(held_state);
   wire deep  = is_deep(held_state);
   wire in_s5 = held_state == swk_pkg::SLP_S5;

   // Per-source permission in the held sleep state
   wire [NS-1:0] allow;
   assign allow[swk_pkg::SRC_LAN]  = light |
                                     (deep & ~in_s5) | (in_s5 & lan_s5_en);
   // Ring only from S1 or S3
   assign allow[swk_pkg::SRC_RING] = light;
   // USB only from S1 or S3
   assign allow[swk_pkg::SRC_USB]  = light;
   // PS/2 only from S1 or S3
   assign allow[swk_pkg::SRC_KBMS] = light;
   // PME# with firmware option; S5 needs its own enable
   assign allow[swk_pkg::SRC_PME]  = pme_wake_en &
                                     (light | (deep & ~in_s5) |
                                      (in_s5 & pme_s5_en));

   wire sleeping  = st == ST_SLEEP;
   // Synchronised levels masked by what the held state permits
   wire [NS-1:0] qual = syi.lvl & allow;
   wire any_wake  = sleeping && (|latch);
   wire wait_done = wait_cnt == 16'(PWR_WAIT - 1);

   // Latch qualified sources until the wake completes
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
         latch <= '0;
      else if (st == ST_RUN)
         latch <= '0;
      else if (sleeping)
         latch <= latch | qual;
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
         held_state <= swk_pkg::SLP_S0;
      else if (st == ST_RUN && sleep_req)
         held_state <= sleep_state;
   end

   always_comb begin
      next_st = st;
      case (st)
         ST_RUN: begin
            if (sleep_req && sleep_state != swk_pkg::SLP_S0)
               next_st = ST_SLEEP;
         end
         ST_SLEEP: begin
            if (any_wake)
               next_st = ST_PWRUP;
         end
         ST_PWRUP: begin
            // Timeout guards against a supply that never reports good
            if (pwr_good || wait_done)
               next_st = ST_WAKE;
         end
         ST_WAKE:  next_st = ST_RUN;
         default:  next_st = ST_RUN;
      endcase
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
         st <= ST_RUN;
      else
         st <= next_st;
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
         wait_cnt <= '0;
      else if (st == ST_PWRUP)
         wait_cnt <= wait_cnt + 16'h0001;
      else
         wait_cnt <= '0;
   end

   // Next values of the registered outputs, decoded once here
   wire entering_s1 = sleep_state == swk_pkg::SLP_S1 && st == ST_RUN;
   wire held_s1     = held_state == swk_pkg::SLP_S1 && st != ST_RUN;

   // Supply off while sleeping in S3 and deeper
   wire       next_pwr    = (next_st != ST_SLEEP) || entering_s1 || held_s1;
   wire [1:0] sleep_lamp  = lamp_dual ? swk_pkg::LAMP_AMBER
                                      : swk_pkg::LAMP_OFF;
   // Amber or dark lamp while asleep
   wire [1:0] next_lamp   = (next_st == ST_SLEEP) ? sleep_lamp
                                                  : swk_pkg::LAMP_GREEN;
   wire       next_pulse  = st == ST_WAKE;
   // Resume saved context only from S1 or S3
   wire       next_resume = (st == ST_WAKE) && light;
   wire       take_cause  = (st == ST_SLEEP) && any_wake;

   // Supply switch; on at reset so a cold start powers the board
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
         main_pwr_on <= 1'b1;
      else
         main_pwr_on <= next_pwr;
   end

   // Front panel lamp
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
         lamp <= swk_pkg::LAMP_GREEN;
      else
         lamp <= next_lamp;
   end

   // One-cycle completion pulse
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
         wake_pulse <= 1'b0;
      else
         wake_pulse <= next_pulse;
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
         resume_ctx <= 1'b0;
      else
         resume_ctx <= next_resume;
   end

   // Cause held until the next wake so software can read it late
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
         wake_cause <= '0;
      else if (take_cause)
         wake_cause <= latch;
   end
endmodule
`default_nettype wire

// [swk_core_checker.sv]
// Checker: port assertions for the wake logic
`timescale 1ns/10ps
`default_nettype none
module swk_core_checker (
   // Clock, reset and inputs
   input wire logic       mclk,
   input wire logic       nrst,
   input wire logic [2:0] sleep_state,
   input wire logic       sleep_req,
   input wire logic       usb_act,
   input wire logic       pme_wake_en,
   input wire logic       lan_s5_en,
   input wire logic       lamp_dual,
   // Outputs
   input wire logic       main_pwr_on,
   input wire logic [1:0] lamp,
   input wire logic       resume_ctx,
   input wire logic       wake_pulse,
   input wire logic [4:0] wake_cause
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   wire s3 = sleep_state == swk_pkg::SLP_S3;
   wire deep = sleep_state >= swk_pkg::SLP_S4;
   s3_entry_a:
      assert property (sleep_req && s3 && lamp == swk_pkg::LAMP_GREEN
         |=> !main_pwr_on) else $error("S3 power");
   lamp_s3_a:
      assert property (!main_pwr_on && s3 |-> lamp == (lamp_dual ?
         swk_pkg::LAMP_AMBER : swk_pkg::LAMP_OFF)) else $error("S3 lamp");
   pulse_one_a:
      assert property (wake_pulse |=> !wake_pulse) else $error("pulse");
   resume_pair_a:
      assert property (resume_ctx |-> wake_pulse && !deep)
         else $error("resume");
   deep_src_a:
      assert property (wake_pulse && deep |-> wake_cause[3:1] == 3'h0)
         else $error("deep wake");
   s5_lan_a:
      assert property (wake_pulse && sleep_state == swk_pkg::SLP_S5
         |-> lan_s5_en || !wake_cause[0]) else $error("S5 LAN");
   pme_gate_a:
      assert property (wake_pulse |-> pme_wake_en || !wake_cause[4])
         else $error("PME gate");
   wake_lat_a:
      assert property ($rose(usb_act) && s3 && !main_pwr_on
         |-> ##[3:6] main_pwr_on) else $error("USB wake late");
   cover property (resume_ctx);
   cover property (wake_pulse && deep);
   cover property (!main_pwr_on);
endmodule
bind swk_core swk_core_checker i_chk (.*);
`default_nettype wire

// [swk_psu_model.sv]
// Model: main supply, good two cycles after switch-on
`timescale 1ns/10ps
`default_nettype none
module swk_psu_model (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic nrst,
   // Supply control and status
   input  wire logic main_pwr_on,
   output logic      pwr_good
);
   logic [1:0] ramp;
   // Rails settle slowly but drop at once when switched off
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) ramp <= 2'h0;
      else ramp <= {ramp[0], main_pwr_on};
   end
   assign pwr_good = main_pwr_on & ramp[1];
endmodule
`default_nettype wire

// [sleep_wake_event_logic_tb.sv]
// Testbench: wake qualification across sleep states
`timescale 1ns/10ps
`default_nettype none
module sleep_wake_event_logic_tb;
   logic       mclk = 0, nrst = 0, req = 0, dual = 1, pg, on, rc, wp;
   logic       pe = 1, l5 = 0, p5 = 0;
   logic [2:0] st = 3'h0;
   logic [2:0] sl[4] = '{3'h1, 3'h3, 3'h4, 3'h5};
   logic [5:0] src = 6'h0;
   logic [1:0] lamp;
   logic [4:0] cause;
   int         fails = 0, check_count = 0;
   always #2.5 mclk = ~mclk;
   swk_core #(.PWR_WAIT(4)) i_dut (.mclk, .nrst, .sleep_state(st),
      .sleep_req(req), .lan_wake(src[0]), .ring_ext(src[1]),
      .ring_int(src[5]), .usb_act(src[2]), .kbms_act(src[3]),
      .pme_n(~src[4]), .pme_wake_en(pe), .lan_s5_en(l5), .pme_s5_en(p5),
      .lamp_dual(dual), .pwr_good(pg), .main_pwr_on(on), .lamp,
      .resume_ctx(rc), .wake_pulse(wp), .wake_cause(cause));
   swk_psu_model i_psu (.mclk, .nrst, .main_pwr_on(on), .pwr_good(pg));
   task automatic chk(string nm, logic [7:0] e, g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Ring drives model a modem whose interrupt software left unmasked
   task automatic pulse(int n, output logic hit, r);
      src[n] = 1;
      @(negedge mclk) src[n] = 0;
      {hit, r} = 2'h0;
      repeat (20) @(negedge mclk) if (wp === 1) {hit, r} = {1'b1, rc};
   endtask
   task automatic try_wake(logic [2:0] s, int n);
      logic ok, hit, r;
      ok = n == 4 ? pe && (s != 3'h5 || p5) : n == 0 ? s != 3'h5 || l5
         : s < 3'h4;
      @(negedge mclk) {dual, st, req} = {n[0], s, 1'b1};
      @(negedge mclk) req = 0;
      if (s == 3'h3) chk("lamp", {1'b0, 5'h0, dual ? swk_pkg::LAMP_AMBER
         : swk_pkg::LAMP_OFF}, {on, 5'h0, lamp});
      pulse(n, hit, r);
      chk("woke", {7'h0, ok}, {7'h0, hit});
      if (ok) chk("cause", {s < 3'h4, 2'h2, 5'(1 << (n == 5 ? 1 : n))},
         {r, on, 1'b0, cause});
      else begin
         // Refused sources leave it asleep, so wake it by PME
         {pe, p5} = 2'h3;
         pulse(4, hit, r);
      end
      {pe, l5, p5} = 3'h4;
      @(negedge mclk);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (8) @(negedge mclk);
      nrst = 1;
      for (int i = 0; i < 24; i++) try_wake(sl[i / 6], i % 6);
      l5 = 1;
      try_wake(3'h5, 0);
      p5 = 1;
      try_wake(3'h5, 4);
      pe = 0;
      try_wake(3'h3, 4);
      complete_run();
   end
   initial begin
      #50us;
      fails++;
      complete_run();
   end
endmodule
`default_nettype wire
